// ==== src/tps_consts.vh ====
// constants for the touch panel scan sequencer
// assumes inclusion by tps_scan.v and the bench files; plain defines, no logic
`ifndef TPS_CONSTS_VH
`define TPS_CONSTS_VH

// ------------------------------------------------------------
// register offsets (4-bit word index)
// ------------------------------------------------------------
`define TPS_ADR_CTRL      4'h0
`define TPS_ADR_COUNT     4'h1
`define TPS_ADR_STATUS    4'h2
`define TPS_ADR_MASK      4'h3
`define TPS_ADR_STATE     4'h4
`define TPS_ADR_PAGE      4'h5
`define TPS_ADR_DATA      4'h6

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define TPS_CTL_ENABLE    0
`define TPS_CTL_HALT      1
`define TPS_CTL_COORD     2
`define TPS_CTL_FIVE      3
`define TPS_CTL_PAGEHALT  4
`define TPS_CTL_RES12     5

// ------------------------------------------------------------
// interrupt status / mask fields
// ------------------------------------------------------------
`define TPS_IRQ_PAGE1     0
`define TPS_IRQ_PAGE2     1
`define TPS_IRQ_RDY       2
`define TPS_IRQ_LOST      3
`define TPS_IRQ_PEN       4

// ------------------------------------------------------------
// sequencer state codes (3-bit field)
// ------------------------------------------------------------
`define TPS_ST_STANDBY    3'h0
`define TPS_ST_SELECT     3'h1
`define TPS_ST_SHIFT      3'h2
`define TPS_ST_WAIT       3'h3
`define TPS_ST_RECEIVE    3'h4
`define TPS_ST_COLLECT    3'h5

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define TPS_RST_COUNT     8'h05
`define TPS_RST_PAGE      8'h10
`define TPS_BATT_CHAN     3'h7
`define TPS_ACK_WAIT_NS   2000
`define TPS_CLK_NS        25
`define TPS_ACK_WAIT_CYC  (`TPS_ACK_WAIT_NS / `TPS_CLK_NS)

`endif

// ==== src/tps_scan.v ====
// touch panel scan sequencer with converter link and dma handshake
// assumes converter_ref_clock, conversion_done, converter_serial_in and
// pen_touch_n are asynchronous pins; dma and register port share clk
//
// Behaviour
// - battery mode takes one sample via dma
// - coordinate mode takes sets of four or five samples until the count
// - page one and page two edge interrupts
// - halt requests at page one edge if set
// - untransferred sample overwritten, flagged lost
// - separate data lost interrupt bit
// - count transfers, ready ends collect state
// - ready forced when converter transfers finish
// - stop requests deferred to set boundary
// - ready marks real stop; software waits it
// - select, serial out, serial in, done pins
// - drive panel voltage control per coordinate measurement
// - active low pen input makes pen interrupt
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tps_consts.vh"

module tps_scan
#(
  parameter RES_W = 12                  // sample width
)
(
  input  wire        clk,
  input  wire        rst_b,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  output reg         irq,
  output reg         dma_req,
  input  wire        dma_ack,
  output reg  [15:0] dma_data,
  input  wire        converter_ref_clock,
  output reg         converter_select_n,
  output reg         converter_serial_out,
  input  wire        converter_serial_in,
  input  wire        conversion_done,
  output reg  [4:0]  panel_drive_ctrl,
  input  wire        pen_touch_n
);

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  reg [3:0] sync_a;                     // first stage, read only by sync_b
  reg [3:0] sync_b;                     // usable copies
  reg       ref_prev;                   // link clock edge detect
  reg       pen_prev;                   // pen level history

  // two flops per asynchronous pin
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_a   <= 4'h8;                 // idle levels: pen up, others low
      sync_b   <= 4'h8;                 // matches history, no false edge
      ref_prev <= 1'b0;
      pen_prev <= 1'b1;
    end
    else
    begin
      sync_a   <= {pen_touch_n, conversion_done, converter_serial_in, converter_ref_clock};
      sync_b   <= sync_a;
      ref_prev <= sync_b[0];
      pen_prev <= sync_b[3];
    end
  end

  wire ref_rise = sync_b[0] & ~ref_prev;  // drive edge of link clock
  wire ref_fall = ~sync_b[0] & ref_prev;  // sample edge of link clock
  wire sdi      = sync_b[1];
  wire eoc      = sync_b[2];
  wire pen_chg  = sync_b[3] ^ pen_prev;

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  reg [5:0]  ctrl;                      // control_reg bits
  reg [7:0]  xfer_target;               // programmed transfer count
  reg [7:0]  page_len;                  // samples per buffer page
  reg [4:0]  status;                    // sticky interrupt bits
  reg [4:0]  mask;                      // interrupt enables
  reg [2:0]  sequencer_state_field;     // state code
  reg        stop_pend;                 // deferred stop
  reg [4:0]  set_evt;                   // event pulses this cycle

  wire wr_ctrl = reg_wr && (reg_addr == `TPS_ADR_CTRL);
  wire wr_stat = reg_wr && (reg_addr == `TPS_ADR_STATUS);

  // ----------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------
  reg [2:0]  chan;                      // sample index in set
  reg [4:0]  bitcnt;                    // link bit counter
  reg [15:0] shreg;                     // receive shift
  reg [15:0] held;                      // sample waiting for dma
  reg        held_ok;                   // held sample valid
  reg [7:0]  done_cnt;                  // transfers completed
  reg [7:0]  page_pos;                  // position in buffer
  reg        page_half;                 // 0 first page, 1 second
  reg        req_block;                 // page halt latch
  reg [15:0] ack_tmr;                   // ack wait timer
  reg        last_set;                  // all samples converted
  reg [7:0]  conv_cnt;                  // samples converted this scan

  wire [2:0] set_len = ctrl[`TPS_CTL_COORD] ?
                       (ctrl[`TPS_CTL_FIVE] ? 3'h5 : 3'h4) : 3'h1;
  wire [4:0] res_bits = ctrl[`TPS_CTL_RES12] ? 5'h0c : 5'h0a;

  // scan over: count reached, or converter done and nothing left to move
  wire scan_fin = (sequencer_state_field == `TPS_ST_COLLECT) &&
                  ((done_cnt >= xfer_target && xfer_target != 8'h00) ||
                   (last_set && !dma_req && !held_ok));

  // main state machine, dma handshake and event generation
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sequencer_state_field <= `TPS_ST_STANDBY;
      converter_select_n    <= 1'b1;
      converter_serial_out  <= 1'b0;
      panel_drive_ctrl      <= 5'h00;
      dma_req               <= 1'b0;
      dma_data              <= 16'h0000;
      chan                  <= 3'h0;
      bitcnt                <= 5'h00;
      shreg                 <= 16'h0000;
      held                  <= 16'h0000;
      held_ok               <= 1'b0;
      done_cnt              <= 8'h00;
      page_pos              <= 8'h00;
      page_half             <= 1'b0;
      req_block             <= 1'b0;
      ack_tmr               <= 16'h0000;
      last_set              <= 1'b0;
      conv_cnt              <= 8'h00;
      stop_pend             <= 1'b0;
      set_evt               <= 5'h00;
    end
    else
    begin
      set_evt <= {pen_chg, 4'h0};
      // stop request latched, honoured at set boundary
      if ((wr_ctrl && (reg_wdata[`TPS_CTL_HALT] || !reg_wdata[`TPS_CTL_ENABLE]))
          && sequencer_state_field != `TPS_ST_STANDBY)
        stop_pend <= 1'b1;
      // dma side: hold request until ack or timeout, present sample on ack
      if (dma_req)
      begin
        if (dma_ack)
        begin
          dma_req  <= 1'b0;
          dma_data <= held;
          held_ok  <= 1'b0;
          done_cnt <= done_cnt + 8'h01;
          if (page_pos + 8'h01 == page_len)
          begin
            page_pos  <= 8'h00;
            page_half <= ~page_half;
            if (!page_half)
            begin
              set_evt[`TPS_IRQ_PAGE1] <= 1'b1;
              if (ctrl[`TPS_CTL_PAGEHALT])
                req_block <= 1'b1;
            end
            else
              set_evt[`TPS_IRQ_PAGE2] <= 1'b1;
          end
          else
            page_pos <= page_pos + 8'h01;
        end
        else if (ack_tmr == `TPS_ACK_WAIT_CYC)
        begin
          dma_req <= 1'b0;                        // ack too late: give up
          held_ok <= 1'b0;
          set_evt[`TPS_IRQ_LOST] <= 1'b1;
        end
        else
          ack_tmr <= ack_tmr + 16'h0001;
      end
      // sample landed in the same cycle as an ack or timeout: request it now
      else if (held_ok && !req_block)
      begin
        dma_req <= 1'b1;
        ack_tmr <= 16'h0000;
      end
      // converter link sequence
      case (sequencer_state_field)
        `TPS_ST_STANDBY:
        begin
          converter_select_n <= 1'b1;
          panel_drive_ctrl   <= 5'h00;
          stop_pend          <= 1'b0;
          if (ctrl[`TPS_CTL_ENABLE] && !ctrl[`TPS_CTL_HALT])
          begin
            chan      <= 3'h0;
            done_cnt  <= 8'h00;
            last_set  <= 1'b0;
            conv_cnt  <= 8'h00;
            req_block <= 1'b0;
            sequencer_state_field <= `TPS_ST_COLLECT;
          end
        end
        `TPS_ST_COLLECT:
        begin
          // ready on count, or forced once converter is done
          if (scan_fin)
          begin
            set_evt[`TPS_IRQ_RDY] <= 1'b1;
            sequencer_state_field <= `TPS_ST_STANDBY;
          end
          else if (!last_set)
            sequencer_state_field <= `TPS_ST_SELECT;
        end
        `TPS_ST_SELECT:
        begin
          // select falls just after a link falling edge, so the first
          // rising edge seen in the frame launches the first command bit
          if (ref_fall)
          begin
            panel_drive_ctrl   <= ctrl[`TPS_CTL_COORD] ? (5'h01 << chan) : 5'h00;
            converter_select_n <= 1'b0;
            shreg  <= {10'h000, 1'b1, ctrl[`TPS_CTL_COORD] ? chan : `TPS_BATT_CHAN,
                       2'h0};
            bitcnt <= 5'h06;
            sequencer_state_field <= `TPS_ST_SHIFT;
          end
        end
        `TPS_ST_SHIFT:
        begin
          if (ref_rise)
          begin
            converter_serial_out <= shreg[5];
            shreg  <= {shreg[14:0], 1'b0};
            bitcnt <= bitcnt - 5'h01;
            if (bitcnt == 5'h01)
              sequencer_state_field <= `TPS_ST_WAIT;
          end
        end
        `TPS_ST_WAIT:
        begin
          if (eoc)
          begin
            bitcnt <= res_bits;
            shreg  <= 16'h0000;
            sequencer_state_field <= `TPS_ST_RECEIVE;
          end
        end
        `TPS_ST_RECEIVE:
        begin
          if (ref_fall)
          begin
            shreg  <= {shreg[14:0], sdi};
            bitcnt <= bitcnt - 5'h01;
            if (bitcnt == 5'h01)
            begin
              converter_select_n <= 1'b1;
              // unsent sample overwritten by the new one
              if ((held_ok && !(dma_req && dma_ack)) || req_block)
                set_evt[`TPS_IRQ_LOST] <= 1'b1;
              conv_cnt <= conv_cnt + 8'h01;
              held    <= {shreg[14:0], sdi};
              held_ok <= !req_block;
              if (!req_block && !dma_req)
              begin
                dma_req <= 1'b1;
                ack_tmr <= 16'h0000;
              end
              if (chan + 3'h1 == set_len)
              begin
                chan <= 3'h0;
                // lost samples count too: stop converting after the set in which conversions reach the count
                if (!ctrl[`TPS_CTL_COORD] || stop_pend ||
                    !ctrl[`TPS_CTL_ENABLE] || ctrl[`TPS_CTL_HALT] ||
                    (xfer_target != 8'h00 && conv_cnt + 8'h01 >= xfer_target))
                  last_set <= 1'b1;
              end
              else
                chan <= chan + 3'h1;
              sequencer_state_field <= `TPS_ST_COLLECT;
            end
          end
        end
        default:
          sequencer_state_field <= `TPS_ST_STANDBY;
      endcase
    end
  end

  // ----------------------------------------------------------
  // register file and interrupt
  // ----------------------------------------------------------
  // writes, sticky status with set over clear
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl        <= 6'h00;
      xfer_target <= `TPS_RST_COUNT;
      page_len    <= `TPS_RST_PAGE;
      status      <= 5'h00;
      mask        <= 5'h00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= reg_wdata[5:0];
      else if (scan_fin)
        ctrl[`TPS_CTL_ENABLE] <= 1'b0;  // one scan per enable, no rerun
      else if (sequencer_state_field == `TPS_ST_STANDBY)
        ctrl[`TPS_CTL_HALT] <= 1'b0;    // halt request consumed
      if (reg_wr && reg_addr == `TPS_ADR_COUNT)
        xfer_target <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `TPS_ADR_PAGE)
        page_len <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `TPS_ADR_MASK)
        mask <= reg_wdata[4:0];
      status <= (status & ~(wr_stat ? reg_wdata[4:0] : 5'h00)) | set_evt;
    end
  end

  // read data one cycle after strobe; level interrupt
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= 16'h0000;
      irq       <= 1'b0;
    end
    else
    begin
      irq <= |(status & mask);
      if (!reg_rd)
        reg_rdata <= 16'h0000;
      else if (reg_addr == `TPS_ADR_CTRL)
        reg_rdata <= {10'h000, ctrl};
      else if (reg_addr == `TPS_ADR_COUNT)
        reg_rdata <= {8'h00, xfer_target};
      else if (reg_addr == `TPS_ADR_STATUS)
        reg_rdata <= {11'h000, status};
      else if (reg_addr == `TPS_ADR_MASK)
        reg_rdata <= {11'h000, mask};
      else if (reg_addr == `TPS_ADR_STATE)
        reg_rdata <= {13'h0000, sequencer_state_field};
      else if (reg_addr == `TPS_ADR_PAGE)
        reg_rdata <= {8'h00, page_len};
      else if (reg_addr == `TPS_ADR_DATA)
        reg_rdata <= done_cnt[7:0] == 8'h00 ? 16'h0000 : dma_data;
      else
        reg_rdata <= 16'h0000;           // unmapped reads zero
    end
  end

endmodule

// ==== tb/tps_scan_checker.sv ====
// concurrent checks on the touch panel scan sequencer ports
// assumes bind onto tps_scan; sees only its ports, one clock domain
`timescale 1ns/1ps
`include "tps_consts.vh"
module tps_scan_checker
(
  input wire        clk,
  input wire        rst_b,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        irq,
  input wire        dma_req,
  input wire        dma_ack,
  input wire        converter_select_n,
  input wire [4:0]  panel_drive_ctrl
);
  // ------------------------------------------------------------
  // request age counter
  // ------------------------------------------------------------
  reg [7:0] req_cnt;  // cycles the request has stood unanswered
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b) req_cnt <= 8'h00;
    else if (!dma_req) req_cnt <= 8'h00;
    else if (req_cnt != 8'hff) req_cnt <= req_cnt + 8'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_REQ_HOLD: assert property (dma_req && !dma_ack && req_cnt < 8'd78 |=> dma_req)
    else $error("request dropped before ack or timeout");
  AST_REQ_ACK: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("request stays after ack");
  AST_REQ_TMO: assert property (req_cnt <= 8'd81)
    else $error("request outlives ack timeout");
  AST_REQ_DROP: assert property ($fell(dma_req) |-> $past(dma_ack) || $past(req_cnt) >= 8'd78)
    else $error("request fell without ack or timeout");
  AST_DRIVE_ONEHOT: assert property ($onehot0(panel_drive_ctrl))
    else $error("panel drive not one-hot");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read answer cycle");
  AST_RDATA_UNMAP: assert property (reg_rd && reg_addr > `TPS_ADR_DATA |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_IRQ_MASK: assert property ((reg_wr && reg_addr == `TPS_ADR_MASK && reg_wdata[4:0] == 5'h00)
    ##1 !(reg_wr && reg_addr == `TPS_ADR_MASK) |=> !irq)
    else $error("irq high with all sources masked");
  // main scenarios seen
  COV_FRAME: cover property ($fell(converter_select_n));
  COV_XFER: cover property (dma_req && dma_ack);
  COV_TMO: cover property ($fell(dma_req) && !$past(dma_ack));
  COV_IRQ: cover property ($rose(irq));
endmodule
bind tps_scan tps_scan_checker chk_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq(irq), .dma_req(dma_req), .dma_ack(dma_ack),
  .converter_select_n(converter_select_n), .panel_drive_ctrl(panel_drive_ctrl));

// ==== tb/tps_adc_model.sv ====
// behavioural serial converter on the far side of the link
// assumes a free-running reference clock; 6 command bits then data
`timescale 1ns/1ps
module tps_adc_model
#(
  parameter [11:0] SMP = 12'h9c5  // value returned by every conversion
)
(
  output reg         converter_ref_clock,
  input  wire        converter_select_n,
  input  wire        converter_serial_out,
  output reg         converter_serial_in,
  output reg         conversion_done,
  output wire [2:0]  chan,
  output integer     frames
);
  reg [5:0] cmd;   // command shift register
  reg [2:0] nbits; // command bits taken
  reg [3:0] bi;    // next data bit index
  assign chan = cmd[4:2];
  initial
  begin
    converter_ref_clock = 1'b0;
    converter_serial_in = 1'b0;
    conversion_done = 1'b0;
    frames = 0;
    nbits = 3'h0;
  end
  // reference clock runs free at 200 ns
  always #100 converter_ref_clock = ~converter_ref_clock;
  // command bits taken on falling edges while selected
  always @(negedge converter_ref_clock)
  begin
    if (converter_select_n) nbits <= 3'h0;
    else if (nbits < 3'h6)
    begin
      cmd <= {cmd[4:0], converter_serial_out};
      nbits <= nbits + 3'h1;
    end
  end
  // done with data msb on one rising edge, lower bits on later rising edges; release shows inverse
  always @(posedge converter_ref_clock or posedge converter_select_n)
  begin
    if (converter_select_n)
    begin
      conversion_done <= 1'b0;
      converter_serial_in <= ~converter_serial_in;
    end
    else if (nbits == 3'h6 && !conversion_done)
    begin
      conversion_done <= 1'b1;
      converter_serial_in <= SMP[11];
      bi <= 4'd10;
    end
    else if (conversion_done)
    begin
      converter_serial_in <= SMP[bi];
      bi <= bi - 4'd1;
    end
  end
  // count finished frames
  always @(posedge converter_select_n) frames <= frames + 1;
endmodule

// ==== tb/tb_tps_scan.sv ====
// self-checking bench for the touch panel scan sequencer
// assumes tps_adc_model on the link and a bench-side dma acknowledger
`timescale 1ns/1ps
`include "tps_consts.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_tps_scan;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg dma_ack = 1'b0;
  reg pen_touch_n = 1'b1;
  wire [15:0] reg_rdata, dma_data;
  wire [4:0] panel_drive_ctrl;
  wire irq, dma_req, lclk, sel_n, sout, sin, done;
  wire [2:0] chan;
  integer frames, num_errors = 0, n_tests = 0, n_xfer = 0, ack_dly = 0, wcnt = 0, x0, f0, i;
  reg ack_on = 1'b1;     // acknowledger answers at all
  reg ack_q = 1'b0;      // ack seen last cycle
  reg [15:0] got, q;     // last transferred word, last read
  localparam [15:0] B12 = (16'h1 << `TPS_CTL_ENABLE) | (16'h1 << `TPS_CTL_RES12);
  localparam [15:0] CRD = 16'h1 << `TPS_CTL_COORD;
  always #12.5 clk = ~clk;
  tps_scan dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .dma_req(dma_req),
    .dma_ack(dma_ack), .dma_data(dma_data), .converter_ref_clock(lclk),
    .converter_select_n(sel_n), .converter_serial_out(sout), .converter_serial_in(sin),
    .conversion_done(done), .panel_drive_ctrl(panel_drive_ctrl), .pen_touch_n(pen_touch_n));
  tps_adc_model adc_u (.converter_ref_clock(lclk), .converter_select_n(sel_n),
    .converter_serial_out(sout), .converter_serial_in(sin), .conversion_done(done),
    .chan(chan), .frames(frames));
  // ------------------------------------------------------------
  // dma controller stand-in: ack after ack_dly cycles, one cycle
  // ------------------------------------------------------------
  always @(posedge clk)
  begin
    dma_ack <= 1'b0;
    ack_q <= dma_ack && dma_req;
    if (ack_q) got <= dma_data;
    if (dma_ack && dma_req) n_xfer <= n_xfer + 1;
    if (dma_req && !dma_ack && ack_on)
    begin
      if (wcnt >= ack_dly)
      begin
        dma_ack <= 1'b1;
        wcnt <= 0;
      end
      else wcnt <= wcnt + 1;
    end
  end
  // ------------------------------------------------------------
  // register port tasks
  // ------------------------------------------------------------
  task wr(input [3:0] a, input [15:0] d);
  begin
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [3:0] a);
  begin
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  end
  endtask
  // poll status until ready; it alone marks a real stop
  task wait_rdy;
  begin
    q = 16'h0000;
    for (i = 0; i < 3000 && q[`TPS_IRQ_RDY] !== 1'b1; i++) rd(`TPS_ADR_STATUS);
    `CHK("ready", 1'b1, q[`TPS_IRQ_RDY])
  end
  endtask
  task reset;
  begin
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
  end
  endtask
  task summarize;
  begin
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  // watchdog: whole run expected well under this span
  initial
  begin
    #1500000;
    num_errors++;
    summarize;
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    reset;
    rd(`TPS_ADR_COUNT);  `CHK("count rst", `TPS_RST_COUNT, q[7:0])
    rd(`TPS_ADR_PAGE);   `CHK("page rst", `TPS_RST_PAGE, q[7:0])
    rd(`TPS_ADR_DATA);   `CHK("data rst", 16'h0000, q)
    rd(4'hf);            `CHK("unmapped", 16'h0000, q)
    // battery: one sample on the battery channel, slow ack
    ack_dly = 20;
    f0 = frames;
    wr(`TPS_ADR_COUNT, 16'h0001);
    wr(`TPS_ADR_CTRL, B12);
    wait_rdy;
    wr(`TPS_ADR_CTRL, 16'h0000);
    `CHK("batt chan", `TPS_BATT_CHAN, chan)
    `CHK("batt frames", 1, frames - f0)
    `CHK("batt xfers", 1, n_xfer)
    `CHK("batt data", 16'h09c5, got)
    rd(`TPS_ADR_STATE);  `CHK("state", {13'h0, `TPS_ST_STANDBY}, q)
    `CHK("irq masked", 1'b0, irq)
    wr(`TPS_ADR_MASK, 16'h1 << `TPS_IRQ_RDY);
    rd(`TPS_ADR_STATE);  `CHK("irq on", 1'b1, irq)
    wr(`TPS_ADR_STATUS, 16'h001f);
    rd(`TPS_ADR_STATE);  `CHK("irq off", 1'b0, irq)
    wr(`TPS_ADR_MASK, 16'h0000);
    // five-sample set, prompt ack, halt request after first word
    ack_dly = 0;
    x0 = n_xfer;
    wr(`TPS_ADR_COUNT, 16'h0008);  // above one set: only the stop ends it
    wr(`TPS_ADR_CTRL, B12 | CRD | (16'h1 << `TPS_CTL_FIVE));
    for (i = 0; i < 20000 && n_xfer == x0; i++) @(posedge clk);
    wr(`TPS_ADR_CTRL, B12 | CRD | (16'h1 << `TPS_CTL_FIVE) | (16'h1 << `TPS_CTL_HALT));
    wait_rdy;
    `CHK("set of five", 5, n_xfer - x0)
    rd(`TPS_ADR_STATE);  `CHK("stopped", {13'h0, `TPS_ST_STANDBY}, q)
    wr(`TPS_ADR_CTRL, 16'h0000);
    wr(`TPS_ADR_STATUS, 16'h001f);
    // no ack at all: timeout, lost, drained ready
    ack_on = 1'b0;
    x0 = n_xfer;
    wr(`TPS_ADR_COUNT, 16'h0001);
    wr(`TPS_ADR_CTRL, B12);
    wait_rdy;
    wr(`TPS_ADR_CTRL, 16'h0000);
    `CHK("lost bit", 1'b1, q[`TPS_IRQ_LOST])
    `CHK("no xfer", 0, n_xfer - x0)
    ack_on = 1'b1;
    // halt on first page edge with page of two, four-sample set
    reset;
    x0 = n_xfer;
    wr(`TPS_ADR_PAGE, 16'h0002);
    wr(`TPS_ADR_COUNT, 16'h0004);
    wr(`TPS_ADR_CTRL, B12 | CRD | (16'h1 << `TPS_CTL_PAGEHALT));
    wait_rdy;
    `CHK("page halt xfers", 2, n_xfer - x0)
    `CHK("page1 bit", 1'b1, q[`TPS_IRQ_PAGE1])
    `CHK("lost after halt", 1'b1, q[`TPS_IRQ_LOST])
    // both page edges without the halt
    reset;
    x0 = n_xfer;
    wr(`TPS_ADR_PAGE, 16'h0002);
    wr(`TPS_ADR_COUNT, 16'h0004);
    wr(`TPS_ADR_CTRL, B12 | CRD);
    wait_rdy;
    wr(`TPS_ADR_CTRL, 16'h0000);
    `CHK("four xfers", 4, n_xfer - x0)
    `CHK("last chan", 3'h3, chan)
    `CHK("page edges", 2'b11, {q[`TPS_IRQ_PAGE2], q[`TPS_IRQ_PAGE1]})
    `CHK("pen idle", 1'b0, q[`TPS_IRQ_PEN])
    // pen touch change reaches status and irq
    wr(`TPS_ADR_MASK, 16'h1 << `TPS_IRQ_PEN);
    pen_touch_n <= 1'b0;
    repeat (10) @(posedge clk);
    rd(`TPS_ADR_STATUS); `CHK("pen bit", 1'b1, q[`TPS_IRQ_PEN])
    `CHK("pen irq", 1'b1, irq)
    summarize;
  end
endmodule
